// *** design/pcb_pkg.sv ***
// Purpose: shared constants for the power-on configuration boot controller
// Assumes: 25 MHz hclk, 32-bit AHB-Lite register access
// Notes: offsets are byte addresses of aligned words
package pcb_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] PCB_CTRL_OFS = 8'h00;   // control bits
    localparam logic [7:0] PCB_STAT_OFS = 8'h04;   // status bits
    localparam logic [7:0] PCB_CMD_OFS = 8'h08;    // flash command
    localparam logic [7:0] PCB_UIDL_OFS = 8'h0C;   // identifier low word
    localparam logic [7:0] PCB_UIDH_OFS = 8'h10;   // identifier high word
    localparam logic [7:0] PCB_RDBK_OFS = 8'h14;   // readback data
    // control field positions
    localparam int PCB_C_MON = 0;     // supply monitor in user mode
    localparam int PCB_C_BGOFF = 1;   // bandgap switched off
    localparam int PCB_C_CRCEN = 2;   // check after configuration
    localparam int PCB_C_SEDOFF = 3;  // soft-error checker off
    localparam int PCB_C_DUAL = 4;    // dual boot enable
    localparam int PCB_C_CLKSEL = 8;  // master clock divider, 8 bits
    localparam logic [31:0] PCB_CTRL_RST = 32'h0000_0000;
    // command codes written at PCB_CMD_OFS
    localparam logic [2:0] PCB_K_NONE = 3'h0;
    localparam logic [2:0] PCB_K_LOCK = 3'h1;     // set security bits
    localparam logic [2:0] PCB_K_OTP = 3'h2;      // set one-time mode
    localparam logic [2:0] PCB_K_ERASE = 3'h3;    // full device erase
    localparam logic [2:0] PCB_K_PROG = 3'h4;     // reprogram flash
    localparam logic [2:0] PCB_K_READ = 3'h5;     // readback request
    // identifier
    localparam int PCB_UID_W = 64;
    localparam int PCB_UID_FACT_W = 56;
    // timing: default master clock 2.08 MHz from 25 MHz
    localparam int PCB_CLK_KHZ = 25000;
    localparam int PCB_MCLK_KHZ = 2080;
    localparam int PCB_MCLK_DIV = PCB_CLK_KHZ / (2 * PCB_MCLK_KHZ);
    localparam int PCB_SED_DIV = 4;   // soft-error checker divider
    localparam int PCB_LOAD_WORDS = 16;  // bytes loaded per image
    typedef enum {
        PCB_S_WAIT, PCB_S_LOAD, PCB_S_GOLD, PCB_S_CHECK, PCB_S_USER
    } pcb_state_type;
endpackage : pcb_pkg

// *** design/pcb_crc.sv ***
// Purpose: crc-16 accumulator used for image and soft-error checks
// Assumes: one byte per enabled step
// Notes: result is registered
`timescale 1ns/1ps
module pcb_crc #(
    parameter int W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic step,
    input wire logic [7:0] data,
    output logic [W-1:0] crc
);
    // ------------------------------------------------------------
    // bitwise update
    // ------------------------------------------------------------
    function automatic logic [W-1:0] upd(logic [W-1:0] c, logic [7:0] d);
        logic [W-1:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = r[W-1] ^ d[7-i] ? ((r << 1) ^ W'(16'h1021)) : (r << 1);
        end
        return r;
    endfunction : upd

    // accumulator register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc <= '1;
        end else if (clear) begin
            crc <= '1;
        end else if (step) begin
            crc <= upd(crc, data);
        end
    end
endmodule : pcb_crc

// *** design/pcb_boot.sv ***
// Purpose: power-on, boot, security and soft-error control
// Assumes: supply comparators arrive as synchronous levels
// Notes: images stream in as bytes followed by a 16-bit crc
//
// How it works
// - load starts once both supplies reach threshold
// - user pins tristate until configuration done
// - core drop in user mode restarts power-up
// - bandgap off selects low-power drop monitor
// - regulated variant also watches external supply
// - security bits block all readback
// - lock clears only with full erase
// - one-time mode rejects erase and program
// - corrupt primary restarts from golden image
// - optional crc check after configuration
// - user input starts soft-error check
// - checker on own divider, can switch off
// - identifier 64 bits, 8 user bits
// - identifier readable over register port
// - load starts at default master clock
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pcb_boot #(
    parameter logic [55:0] FACTORY_ID = 56'h00_0000_1234_5678, // arbitrary
    parameter bit REGULATED = 1'b1,
    parameter int IO_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // supply comparators, high when above level
    input wire logic core_internal_supply,
    input wire logic config_bank_supply,
    input wire logic external_supply,
    input wire logic bandgap_drop_threshold,
    input wire logic low_power_drop_threshold,
    // image byte stream
    input wire logic img_valid,
    input wire logic [7:0] img_data,
    output logic img_golden,
    output logic master_clk,
    // user pins
    input wire logic [IO_W-1:0] user_out,
    output logic [IO_W-1:0] pad_out,
    output logic [IO_W-1:0] pad_oe_n,
    // soft error start and memory bytes
    input wire logic sed_start,
    input wire logic [7:0] cfg_byte,
    output logic right_side_pll_reset,
    output logic done,
    output logic error
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic wr_reg, rd_reg;            // data phase pending
    logic [7:0] addr_reg;            // latched address
    logic [31:0] ctrl_reg;           // control word
    logic lock_reg, otp_reg;         // security and one-time bits
    logic [7:0] user_id_reg;         // user part of identifier
    logic [31:0] rdbk_reg;           // last readback value
    logic rdbk_denied_reg;           // readback refused
    logic prog_reg;                  // background programming active
    logic reject_reg;                // last command rejected
    logic [3:0] prog_cnt_reg;        // programming duration
    pcb_pkg::pcb_state_type state_reg;
    logic corrupt_reg, sed_err_reg;
    logic access;
    assign access = hsel && hready && htrans[1] && hsize == 3'h2;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_reg <= access && hwrite;
            rd_reg <= access && !hwrite;
            if (access) begin
                addr_reg <= haddr;
            end
        end
    end

    // control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= pcb_pkg::PCB_CTRL_RST;
        end else if (wr_reg && addr_reg == pcb_pkg::PCB_CTRL_OFS) begin
            ctrl_reg <= hwdata;
        end
    end

    // commands: security, one-time, erase, program, readback
    logic cmd;
    logic [2:0] op;
    assign cmd = wr_reg && addr_reg == pcb_pkg::PCB_CMD_OFS;
    assign op = hwdata[2:0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_reg <= 1'b0;
            otp_reg <= 1'b0;
            user_id_reg <= 8'h00;
            rdbk_reg <= 32'h0000_0000;
            rdbk_denied_reg <= 1'b0;
            prog_reg <= 1'b0;
            reject_reg <= 1'b0;
            prog_cnt_reg <= 4'h0;
        end else begin
            if (prog_reg) begin
                prog_cnt_reg <= prog_cnt_reg - 4'h1;
                if (prog_cnt_reg == 4'h1) begin
                    prog_reg <= 1'b0;
                end
            end
            if (cmd) begin
                reject_reg <= 1'b0;
                rdbk_denied_reg <= 1'b0;
                case (op)
                    pcb_pkg::PCB_K_LOCK: lock_reg <= 1'b1;
                    pcb_pkg::PCB_K_OTP: otp_reg <= 1'b1;
                    pcb_pkg::PCB_K_ERASE: begin
                        if (otp_reg) begin
                            reject_reg <= 1'b1;
                        end else begin
                            lock_reg <= 1'b0;
                            user_id_reg <= 8'h00;
                        end
                    end
                    pcb_pkg::PCB_K_PROG: begin
                        if (otp_reg) begin
                            reject_reg <= 1'b1;
                        end else begin
                            user_id_reg <= hwdata[15:8];
                            prog_reg <= 1'b1;
                            prog_cnt_reg <= 4'hF;
                        end
                    end
                    pcb_pkg::PCB_K_READ: begin
                        if (lock_reg) begin
                            rdbk_denied_reg <= 1'b1;
                            rdbk_reg <= 32'h0000_0000;
                        end else begin
                            rdbk_reg <= {24'h00_0000, cfg_byte};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
    assign right_side_pll_reset = prog_reg;

    // read mux
    logic [63:0] uid;
    assign uid = {user_id_reg, FACTORY_ID};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (access && !hwrite) begin
            case (haddr)
                pcb_pkg::PCB_CTRL_OFS: hrdata <= ctrl_reg;
                pcb_pkg::PCB_STAT_OFS: hrdata <= {22'h00_0000,
                    rdbk_denied_reg, reject_reg, prog_reg, otp_reg,
                    lock_reg, sed_err_reg, corrupt_reg, error, img_golden,
                    done};
                pcb_pkg::PCB_UIDL_OFS: hrdata <= uid[31:0];
                pcb_pkg::PCB_UIDH_OFS: hrdata <= uid[63:32];
                pcb_pkg::PCB_RDBK_OFS: hrdata <= rdbk_reg;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // supply monitoring
    // ------------------------------------------------------------
    logic supplies_up, core_ok;
    assign supplies_up = core_internal_supply && config_bank_supply
        && (!REGULATED || external_supply);
    assign core_ok = (ctrl_reg[pcb_pkg::PCB_C_BGOFF]
        ? low_power_drop_threshold : bandgap_drop_threshold)
        && (!REGULATED || external_supply);
    logic drop;
    assign drop = ctrl_reg[pcb_pkg::PCB_C_MON] && !core_ok;

    // ------------------------------------------------------------
    // master clock divider, default 2.08 MHz until select bits come
    // ------------------------------------------------------------
    logic [7:0] mdiv_reg, mcnt_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdiv_reg <= 8'(pcb_pkg::PCB_MCLK_DIV);
            mcnt_reg <= 8'h00;
            master_clk <= 1'b0;
        end else begin
            if (state_reg == pcb_pkg::PCB_S_WAIT) begin
                mdiv_reg <= 8'(pcb_pkg::PCB_MCLK_DIV);
            end else if (ctrl_reg[15:8] != 8'h00) begin
                mdiv_reg <= ctrl_reg[15:8];
            end
            if (mcnt_reg + 8'h01 >= mdiv_reg) begin
                mcnt_reg <= 8'h00;
                master_clk <= !master_clk;
            end else begin
                mcnt_reg <= mcnt_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // boot sequencer
    // ------------------------------------------------------------
    logic [4:0] cnt_reg;
    logic [15:0] crc;
    logic [15:0] rx_reg;
    logic crc_clear, crc_step;
    logic sed_busy_reg;
    logic [1:0] sed_div_reg;
    logic [4:0] sed_cnt_reg;
    logic [15:0] sed_ref_reg;
    logic in_body;
    assign in_body = cnt_reg < 5'(pcb_pkg::PCB_LOAD_WORDS);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= pcb_pkg::PCB_S_WAIT;
            cnt_reg <= 5'h00;
            rx_reg <= 16'h0000;
            corrupt_reg <= 1'b0;
            img_golden <= 1'b0;
        end else begin
            case (state_reg)
                pcb_pkg::PCB_S_WAIT: begin
                    cnt_reg <= 5'h00;
                    img_golden <= 1'b0;
                    if (supplies_up) begin
                        state_reg <= pcb_pkg::PCB_S_LOAD;
                        corrupt_reg <= 1'b0;
                    end
                end
                pcb_pkg::PCB_S_LOAD, pcb_pkg::PCB_S_GOLD: begin
                    if (img_valid) begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (!in_body) begin
                            rx_reg <= {rx_reg[7:0], img_data};
                        end
                    end
                    if (cnt_reg == 5'(pcb_pkg::PCB_LOAD_WORDS + 2)) begin
                        cnt_reg <= 5'h00;
                        if (rx_reg == crc) begin
                            state_reg <= pcb_pkg::PCB_S_CHECK;
                        end else if (state_reg == pcb_pkg::PCB_S_LOAD
                            && ctrl_reg[pcb_pkg::PCB_C_DUAL]) begin
                            corrupt_reg <= 1'b1;
                            img_golden <= 1'b1;
                            state_reg <= pcb_pkg::PCB_S_GOLD;
                        end else begin
                            corrupt_reg <= 1'b1;
                            state_reg <= pcb_pkg::PCB_S_WAIT;
                        end
                    end
                end
                pcb_pkg::PCB_S_CHECK: begin
                    if (!ctrl_reg[pcb_pkg::PCB_C_CRCEN] || !sed_busy_reg) begin
                        state_reg <= pcb_pkg::PCB_S_USER;
                    end
                end
                pcb_pkg::PCB_S_USER: begin
                    if (drop) begin
                        state_reg <= pcb_pkg::PCB_S_WAIT;
                    end
                end
                default: state_reg <= pcb_pkg::PCB_S_WAIT;
            endcase
            if (drop && state_reg == pcb_pkg::PCB_S_USER) begin
                cnt_reg <= 5'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // soft-error checker on its own divided clock enable
    // ------------------------------------------------------------
    logic sed_tick, sed_go;
    assign sed_tick = sed_div_reg == 2'(pcb_pkg::PCB_SED_DIV - 1);
    assign sed_go = !ctrl_reg[pcb_pkg::PCB_C_SEDOFF] && !sed_busy_reg
        && ((state_reg == pcb_pkg::PCB_S_USER && sed_start)
        || (state_reg == pcb_pkg::PCB_S_CHECK
        && ctrl_reg[pcb_pkg::PCB_C_CRCEN] && !sed_err_reg));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sed_div_reg <= 2'h0;
            sed_busy_reg <= 1'b0;
            sed_cnt_reg <= 5'h00;
            sed_ref_reg <= 16'h0000;
            sed_err_reg <= 1'b0;
        end else begin
            if (ctrl_reg[pcb_pkg::PCB_C_SEDOFF]) begin
                sed_div_reg <= 2'h0;
                sed_busy_reg <= 1'b0;
            end else begin
                sed_div_reg <= sed_div_reg + 2'h1;
            end
            if (state_reg == pcb_pkg::PCB_S_CHECK && sed_cnt_reg == 5'h00
                && !sed_busy_reg) begin
                sed_ref_reg <= rx_reg;
            end
            if (sed_go) begin
                sed_busy_reg <= 1'b1;
                sed_cnt_reg <= 5'h00;
            end else if (sed_busy_reg && sed_tick) begin
                sed_cnt_reg <= sed_cnt_reg + 5'h01;
                if (sed_cnt_reg == 5'(pcb_pkg::PCB_LOAD_WORDS)) begin
                    sed_busy_reg <= 1'b0;
                    sed_cnt_reg <= 5'h00;
                    sed_err_reg <= crc != sed_ref_reg;
                end
            end
        end
    end

    // crc engine shared by loader and checker
    assign crc_clear = (state_reg == pcb_pkg::PCB_S_WAIT) || sed_go
        || (cnt_reg == 5'(pcb_pkg::PCB_LOAD_WORDS + 2));
    assign crc_step = sed_busy_reg ? (sed_tick && sed_cnt_reg <
        5'(pcb_pkg::PCB_LOAD_WORDS)) : (img_valid && in_body
        && state_reg inside {pcb_pkg::PCB_S_LOAD, pcb_pkg::PCB_S_GOLD});
    pcb_crc #(.W(16)) u_crc (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(crc_clear),
        .step(crc_step),
        .data(sed_busy_reg ? cfg_byte : img_data),
        .crc(crc)
    );

    // ------------------------------------------------------------
    // user pins and flags
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out <= '0;
            pad_oe_n <= '1;
            done <= 1'b0;
            error <= 1'b0;
        end else begin
            done <= state_reg == pcb_pkg::PCB_S_USER && !drop;
            error <= corrupt_reg || sed_err_reg;
            if (state_reg == pcb_pkg::PCB_S_USER && !drop) begin
                pad_out <= user_out;
                pad_oe_n <= '0;
            end else begin
                pad_out <= '0;
                pad_oe_n <= '1;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    pads_tristate_a: assert property (@(posedge hclk)
        disable iff (!hresetn) !done |-> pad_oe_n == '1)
        else $error("pads driven early");
    drop_reset_a: assert property (@(posedge hclk)
        disable iff (!hresetn) state_reg == pcb_pkg::PCB_S_USER && drop
        |=> state_reg == pcb_pkg::PCB_S_WAIT) else $error("no reset");
    lock_read_a: assert property (@(posedge hclk)
        disable iff (!hresetn) cmd && op == pcb_pkg::PCB_K_READ && lock_reg
        |=> rdbk_reg == 32'h0 && rdbk_denied_reg) else $error("read");
    otp_erase_a: assert property (@(posedge hclk)
        disable iff (!hresetn) cmd && op == pcb_pkg::PCB_K_ERASE && otp_reg
        |=> $stable(lock_reg) && reject_reg) else $error("erase");
    pll_hold_a: assert property (@(posedge hclk)
        disable iff (!hresetn) cmd && op == pcb_pkg::PCB_K_PROG && !otp_reg
        |=> right_side_pll_reset) else $error("pll");
    start_load_a: assert property (@(posedge hclk)
        disable iff (!hresetn) state_reg == pcb_pkg::PCB_S_WAIT && supplies_up
        |=> state_reg == pcb_pkg::PCB_S_LOAD) else $error("load");
    golden_a: assert property (@(posedge hclk)
        disable iff (!hresetn) $rose(img_golden) |-> corrupt_reg
        && state_reg == pcb_pkg::PCB_S_GOLD) else $error("golden");
    sed_off_a: assert property (@(posedge hclk)
        disable iff (!hresetn) ctrl_reg[pcb_pkg::PCB_C_SEDOFF]
        |=> !sed_busy_reg) else $error("checker on");
    user_c: cover property (@(posedge hclk) $rose(done));
    gold_c: cover property (@(posedge hclk) $rose(img_golden));
    sed_c: cover property (@(posedge hclk) $rose(sed_err_reg));
endmodule : pcb_boot

// *** verification/pcb_flash_model.sv ***
// Purpose: external serial flash that holds the golden image
// Assumes: streams one whole image each time golden loading starts
// Notes: lag sets how slowly the flash answers
`timescale 1ns/1ps
module pcb_flash_model #(
    parameter int LAG = 5
) (
    input wire logic hclk,
    input wire logic img_golden,
    output logic f_valid,
    output logic [7:0] f_data
);
    // crc-16 of 16 bytes counting up from base
    function automatic logic [15:0] crc16(input logic [7:0] base);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < 16; i++) begin
            c = c ^ {base + 8'(i), 8'h00};
            for (int b = 0; b < 8; b++) begin
                c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc16
    // golden body counts up from A0, crc follows msb first
    initial begin
        logic [15:0] g;
        g = crc16(8'hA0);
        f_valid = 1'b0;
        f_data = 8'h00;
        forever begin
            @(posedge img_golden);
            repeat (LAG) @(posedge hclk);
            for (int i = 0; i < 18; i++) begin
                f_valid <= 1'b1;
                f_data <= i < 16 ? 8'hA0 + 8'(i) : (i == 16 ? g[15:8] : g[7:0]);
                @(posedge hclk);
            end
            // released line shows the inverse, never the last byte
            f_valid <= 1'b0;
            f_data <= ~f_data;
        end
    end
endmodule : pcb_flash_model

// *** verification/tb_power_on_config_boot_control.sv ***
// Purpose: self-checking bench for the boot controller
// Assumes: zero-wait ahb-lite slave, comparators as levels
// Notes: primary image from the bench, golden from the flash model
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_power_on_config_boot_control;
    localparam logic [55:0] UID = 56'h5A_0042_0099_1357; // arbitrary
    typedef struct {logic [31:0] wd, mask, exp;} pcb_row_type;
    // command written, status mask, status expected
    pcb_row_type rows [7] = '{
        '{32'h1, 32'h20, 32'h20}, '{32'h5, 32'h200, 32'h200},
        '{32'h3, 32'h20, 32'h0}, '{32'h3C04, 32'h80, 32'h80},
        '{32'h2, 32'h40, 32'h40}, '{32'h4, 32'h100, 32'h100},
        '{32'h3, 32'h140, 32'h140}};
    int bad_count = 0, total_checks = 0;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [7:0] haddr = 8'h00, img_data, t_data = 8'h00, f_data;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic core = 1'b1, bank = 1'b1, ext = 1'b0, bg_thr = 1'b1, lp_thr = 1'b1;
    logic img_valid, t_valid = 1'b0, f_valid, img_golden, master_clk;
    logic [7:0] pad_out, pad_oe_n, user_out = 8'h5A;
    logic pll_rst, done, error;
    logic sed_start = 1'b0;
    logic [7:0] cfg = 8'hC3;
    time t0;
    // golden loading hands the stream to the flash model
    assign img_valid = img_golden ? f_valid : t_valid;
    assign img_data = img_golden ? f_data : t_data;
    always #20 hclk = ~hclk;
    pcb_boot #(.FACTORY_ID(UID)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .core_internal_supply(core), .config_bank_supply(bank),
        .external_supply(ext), .bandgap_drop_threshold(bg_thr),
        .low_power_drop_threshold(lp_thr), .img_valid(img_valid),
        .img_data(img_data), .img_golden(img_golden),
        .master_clk(master_clk), .user_out(user_out), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .sed_start(sed_start), .cfg_byte(cfg),
        .right_side_pll_reset(pll_rst), .done(done), .error(error));
    pcb_flash_model #(.LAG(5)) u_flash (.hclk(hclk),
        .img_golden(img_golden), .f_valid(f_valid), .f_data(f_data));
    // one word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    // primary image of 16 bytes plus crc, optionally spoiled
    task automatic send(input logic spoil);
        logic [15:0] c;
        c = u_flash.crc16(8'h10) ^ {15'h0, spoil};
        for (int i = 0; i < 18; i++) begin
            t_valid <= 1'b1;
            t_data <= i < 16 ? 8'h10 + 8'(i) : (i == 16 ? c[15:8] : c[7:0]);
            @(posedge hclk);
        end
        t_valid <= 1'b0;
        t_data <= ~t_data;
    endtask : send
    task automatic wait_done();
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge hclk);
        repeat (2) @(posedge hclk);
    endtask : wait_done
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // hang guard
    initial begin
        #(40 * 5000);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        `CHK(pad_oe_n, 8'hFF)
        send(1'b0);
        repeat (20) @(posedge hclk);
        `CHK(done, 1'b0)
        ext <= 1'b1;
        repeat (2) @(posedge hclk);
        send(1'b0);
        wait_done();
        `CHK(done, 1'b1)
        `CHK(pad_oe_n, 8'h00)
        `CHK(pad_out, 8'h5A)
        @(posedge master_clk);
        t0 = $time;
        @(negedge master_clk);
        `CHK(($time - t0) / 40, pcb_pkg::PCB_MCLK_DIV)
        foreach (rows[i]) begin
            bus(pcb_pkg::PCB_CMD_OFS, 1'b1, rows[i].wd);
            bus(pcb_pkg::PCB_STAT_OFS, 1'b0, 32'h0);
            if (rows[i].mask[7]) `CHK(pll_rst, 1'b1)
            `CHK(rd & rows[i].mask, rows[i].exp)
        end
        bus(pcb_pkg::PCB_UIDL_OFS, 1'b0, 32'h0);
        `CHK(rd, UID[31:0])
        bus(pcb_pkg::PCB_UIDH_OFS, 1'b0, 32'h0);
        `CHK(rd, {8'h3C, UID[55:32]})
        `CHK(hresp, 1'b0)
        bus(pcb_pkg::PCB_CTRL_OFS, 1'b1, 32'h13);
        bg_thr <= 1'b0;
        repeat (10) @(posedge hclk);
        `CHK(done, 1'b1)
        lp_thr <= 1'b0;
        repeat (10) @(posedge hclk);
        `CHK(done, 1'b0)
        `CHK(pad_oe_n, 8'hFF)
        bg_thr <= 1'b1;
        lp_thr <= 1'b1;
        repeat (2) @(posedge hclk);
        send(1'b1);
        repeat (4) @(posedge hclk);
        `CHK(img_golden, 1'b1)
        wait_done();
        `CHK(done, 1'b1)
        `CHK(error, 1'b1)
        // user request starts the checker; memory bytes differ from image
        sed_start <= 1'b1;
        @(posedge hclk);
        sed_start <= 1'b0;
        repeat (80) @(posedge hclk);
        bus(pcb_pkg::PCB_STAT_OFS, 1'b0, 32'h0);
        `CHK(rd & 32'h10, 32'h10)
        // reset in mid-run clears flags and the user identifier bits
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK(done | error | img_golden, 1'b0)
        `CHK(pad_oe_n, 8'hFF)
        hresetn <= 1'b1;
        bus(pcb_pkg::PCB_UIDH_OFS, 1'b0, 32'h0);
        `CHK(rd, {8'h00, UID[55:32]})
        wrap_up();
    end
endmodule : tb_power_on_config_boot_control
